// ### rtl/autoneg_strap_pkg.sv
// Constants for the strap-driven auto-negotiation configuration block
package autoneg_strap_pkg;
  localparam logic [7:0] OFS_BMC = 8'h00;
  localparam logic [7:0] OFS_ADV = 8'h04;
  localparam logic [7:0] OFS_STS = 8'h10;
  localparam int BMC_SPEED = 13;
  localparam int BMC_ANEN = 12;
  localparam int BMC_RESTART = 9;
  localparam int BMC_DUPLEX = 8;
  localparam int STS_STRAPAN = 9;
  localparam int STS_DUPLEX = 2;
  localparam int STS_SPEED10 = 1;
  localparam int STS_ANDONE = 4;
  localparam int STS_LINK = 0;
  localparam int ADV_T10H = 5;
  localparam int ADV_T10F = 6;
  localparam int ADV_T100H = 7;
  localparam int ADV_T100F = 8;
  localparam logic [15:0] BMC_RESET = 16'h3100;
  localparam logic [8:0] ADV_F10H = 9'h021;
  localparam logic [8:0] ADV_F10F = 9'h041;
  localparam logic [8:0] ADV_F100H = 9'h081;
  localparam logic [8:0] ADV_F100F = 9'h101;
  localparam logic [8:0] ADV_ALL = 9'h1e1;
  localparam logic [8:0] ADV_10ONLY = 9'h061;
  localparam logic [8:0] ADV_100ONLY = 9'h181;
  localparam logic [8:0] ADV_HALF = 9'h0a1;
  localparam logic [8:0] ADV_10HALF = 9'h021;
  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} level_type;
  typedef enum {ST_WAIT, ST_RUN} phase_type;
endpackage

// ### rtl/autoneg_strap_config.sv
// Strap loader, control registers and mode resolution
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: Each strap decodes two comparator outputs into low, mid or high.
// R2: Sampled straps set status bit 9 and advertisement bits 8 to 5.
// R3: Reset defaults enable negotiation and advertise all four abilities.
// R4: Status bit 9 is one for advertised modes, zero for forced modes.
// R5: Software writes to control register change negotiation function anytime.
// R6: While negotiating, advertise exactly the advertisement register abilities.
// R7: Advertisement ability bits are writable in any combination.
// R8: Straps never affect control register contents.
// R9: Status speed and duplex valid only when forced or negotiation complete.
// R10: Negotiated mode is highest priority ability common to both sides.
// R11: High strap 0, low mid: forced 10 half, adv 021h.
// R12: High strap 1, low mid: forced 10 full, adv 041h.
// R13: High mid, low 0: forced 100 half, adv 081h.
// R14: High mid, low 1: forced 100 full, adv 101h.
// R15: Both mid: negotiate all four abilities, adv 1E1h.
// R16: Both 0: negotiate 10 half and full, adv 061h.
// R17: High 0, low 1: negotiate 100 half and full, adv 181h.
// R18: High 1, low 0: negotiate half duplex both speeds, adv 0A1h.
// R19: Both 1: negotiate 10 half only, adv 021h.
// R20: Priority: 100 full, 100 half, 10 full, 10 half.
// R21: Negotiation off: bit 13 speed, bit 8 duplex; ignored when on.
// R22: Straps captured once after reset release, later changes ignored.
module autoneg_strap_config
  import autoneg_strap_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Strap comparator pairs (a, b) per pin
  input wire logic strapLowA,
  input wire logic strapLowB,
  input wire logic strapHighA,
  input wire logic strapHighB,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  // Negotiation engine side
  input wire logic [8:0] partnerAbility,
  input wire logic anComplete,
  input wire logic linkUp,
  output logic [8:0] flpAbility,
  output logic flpEnable,
  output logic anRestart,
  output logic speed10,
  output logic fullDuplex,
  output logic modeValid
);
  logic [3:0] strapS1_r, strapS2_r;
  logic [15:0] bmc_r, bmc_nxt;
  logic [8:0] adv_r, adv_nxt;
  logic strapAn_r, strapAn_nxt;
  logic forceSpd10_r, forceSpd10_nxt, forceFdx_r, forceFdx_nxt;
  phase_type phase_r, phase_nxt;
  logic [15:0] rdata_nxt;
  logic restart_nxt, spd_nxt, fdx_nxt, valid_nxt;
  level_type lvlLow, lvlHigh;
  logic [15:0] stsWord;

  // Straps are board pins, so two flops before any decode
  // No reset here: the pair keeps tracking the pins while rst is held,
  // so the capture edge right after release sees settled levels
  always_ff @(posedge clk_sys) begin
    strapS1_r <= {strapHighB, strapHighA, strapLowB, strapLowA};
    strapS2_r <= strapS1_r;
  end

  function automatic level_type decode(input logic a, input logic b);
    if (a && b) decode = LVL_HIGH; // R1
    else if (!a && b) decode = LVL_MID; // R1
    else decode = LVL_LOW; // R1
  endfunction

  always_comb begin
    lvlLow = decode(strapS2_r[0], strapS2_r[1]);
    lvlHigh = decode(strapS2_r[2], strapS2_r[3]);
  end

  always_comb begin
    stsWord = 16'h0000;
    stsWord[STS_STRAPAN] = strapAn_r; // R4
    stsWord[STS_SPEED10] = speed10;
    stsWord[STS_DUPLEX] = fullDuplex;
    stsWord[STS_ANDONE] = anComplete;
    stsWord[STS_LINK] = linkUp;
  end

  always_comb begin
    bmc_nxt = bmc_r;
    adv_nxt = adv_r;
    strapAn_nxt = strapAn_r;
    forceSpd10_nxt = forceSpd10_r;
    forceFdx_nxt = forceFdx_r;
    phase_nxt = phase_r;
    restart_nxt = 1'b0;
    case (phase_r)
      ST_WAIT: begin
        // First edge after release; the synchroniser already holds the pins
        phase_nxt = ST_RUN; // R22
        strapAn_nxt = 1'b1;
        forceSpd10_nxt = 1'b0;
        forceFdx_nxt = 1'b0;
        case ({lvlHigh, lvlLow}) // R2
          {LVL_LOW, LVL_MID}: begin
            adv_nxt = ADV_F10H; // R11
            strapAn_nxt = 1'b0;
            forceSpd10_nxt = 1'b1;
          end
          {LVL_HIGH, LVL_MID}: begin
            adv_nxt = ADV_F10F; // R12
            strapAn_nxt = 1'b0;
            forceSpd10_nxt = 1'b1;
            forceFdx_nxt = 1'b1;
          end
          {LVL_MID, LVL_LOW}: begin
            adv_nxt = ADV_F100H; // R13
            strapAn_nxt = 1'b0;
          end
          {LVL_MID, LVL_HIGH}: begin
            adv_nxt = ADV_F100F; // R14
            strapAn_nxt = 1'b0;
            forceFdx_nxt = 1'b1;
          end
          {LVL_MID, LVL_MID}: adv_nxt = ADV_ALL; // R15
          {LVL_LOW, LVL_LOW}: adv_nxt = ADV_10ONLY; // R16
          {LVL_LOW, LVL_HIGH}: adv_nxt = ADV_100ONLY; // R17
          {LVL_HIGH, LVL_LOW}: adv_nxt = ADV_HALF; // R18
          default: adv_nxt = ADV_10HALF; // R19
        endcase
      end
      ST_RUN: begin
        if (regWrite && regAddr == OFS_BMC) begin
          bmc_nxt = regWdata; // R5
          bmc_nxt[BMC_RESTART] = 1'b0;
          restart_nxt = regWdata[BMC_RESTART] | (regWdata[BMC_ANEN]
            & ~bmc_r[BMC_ANEN]);
          // Status bit 9 keeps the strap result after software takes over
          strapAn_nxt = strapAn_r;
        end
        if (regWrite && regAddr == OFS_ADV) begin
          adv_nxt = regWdata[8:0]; // R7
        end
      end
      default: phase_nxt = ST_WAIT;
    endcase
  end

  // Forced straps override negotiation until software writes the control word
  logic swOwns_r, swOwns_nxt;
  logic anOn;
  always_comb begin
    swOwns_nxt = swOwns_r | (regWrite && regAddr == OFS_BMC &&
      phase_r == ST_RUN);
    anOn = swOwns_r ? bmc_r[BMC_ANEN] : strapAn_r; // R5
  end

  always_comb begin
    spd_nxt = speed10;
    fdx_nxt = fullDuplex;
    valid_nxt = 1'b0;
    if (!anOn) begin
      if (swOwns_r) begin
        spd_nxt = ~bmc_r[BMC_SPEED]; // R21
        fdx_nxt = bmc_r[BMC_DUPLEX]; // R21
      end else begin
        spd_nxt = forceSpd10_r;
        fdx_nxt = forceFdx_r;
      end
      valid_nxt = 1'b1; // R9
    end else if (anComplete) begin
      valid_nxt = 1'b1; // R9
      if (adv_r[ADV_T100F] && partnerAbility[ADV_T100F]) begin
        spd_nxt = 1'b0; // R20
        fdx_nxt = 1'b1;
      end else if (adv_r[ADV_T100H] && partnerAbility[ADV_T100H]) begin
        spd_nxt = 1'b0; // R20
        fdx_nxt = 1'b0;
      end else if (adv_r[ADV_T10F] && partnerAbility[ADV_T10F]) begin
        spd_nxt = 1'b1; // R10
        fdx_nxt = 1'b1;
      end else if (adv_r[ADV_T10H] && partnerAbility[ADV_T10H]) begin
        spd_nxt = 1'b1; // R10
        fdx_nxt = 1'b0;
      end else begin
        valid_nxt = 1'b0;
      end
    end
    case (regAddr)
      OFS_BMC: rdata_nxt = bmc_r;
      OFS_ADV: rdata_nxt = {7'h00, adv_r};
      OFS_STS: rdata_nxt = stsWord;
      default: rdata_nxt = 16'h0000;
    endcase
    if (!regRead) rdata_nxt = regRdata;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bmc_r <= BMC_RESET; // R3 R8
      adv_r <= ADV_ALL; // R3
      strapAn_r <= 1'b1;
      forceSpd10_r <= 1'b0;
      forceFdx_r <= 1'b0;
      phase_r <= ST_WAIT;
      swOwns_r <= 1'b0;
      regRdata <= 16'h0000;
      flpAbility <= 9'h000;
      flpEnable <= 1'b0;
      anRestart <= 1'b0;
      speed10 <= 1'b0;
      fullDuplex <= 1'b0;
      modeValid <= 1'b0;
    end else begin
      bmc_r <= bmc_nxt;
      adv_r <= adv_nxt;
      strapAn_r <= strapAn_nxt;
      forceSpd10_r <= forceSpd10_nxt;
      forceFdx_r <= forceFdx_nxt;
      phase_r <= phase_nxt;
      swOwns_r <= swOwns_nxt;
      regRdata <= rdata_nxt;
      flpAbility <= adv_r; // R6
      flpEnable <= anOn && phase_r == ST_RUN; // R6
      anRestart <= restart_nxt;
      speed10 <= spd_nxt;
      fullDuplex <= fdx_nxt;
      modeValid <= valid_nxt;
    end
  end

  chk_strap_once: assert property (@(posedge clk_sys) disable iff (rst) // R22
    phase_r == ST_RUN |=> phase_r == ST_RUN)
    else $error("strap capture repeated");
  chk_both_mid: assert property (@(posedge clk_sys) disable iff (rst) // R15
    phase_r == ST_WAIT && lvlLow == LVL_MID && lvlHigh == LVL_MID
    |=> adv_r == ADV_ALL && strapAn_r)
    else $error("mid straps wrong advertisement");
  chk_forced_sts: assert property (@(posedge clk_sys) disable iff (rst) // R4
    phase_r == ST_WAIT && (lvlLow == LVL_MID) != (lvlHigh == LVL_MID)
    |=> !strapAn_r)
    else $error("forced strap left negotiation on");
  chk_flp_adv: assert property (@(posedge clk_sys) disable iff (rst) // R6
    flpEnable |-> flpAbility == $past(adv_r))
    else $error("burst abilities differ from register");
  chk_adv_write: assert property (@(posedge clk_sys) disable iff (rst) // R7
    phase_r == ST_RUN && regWrite && regAddr == OFS_ADV
    |=> adv_r == $past(regWdata[8:0]))
    else $error("advertisement write lost");
  chk_bmc_write: assert property (@(posedge clk_sys) disable iff (rst) // R5
    phase_r == ST_RUN && regWrite && regAddr == OFS_BMC
    |=> bmc_r[BMC_ANEN] == $past(regWdata[BMC_ANEN]))
    else $error("control write lost");
  chk_valid_gate: assert property (@(posedge clk_sys) disable iff (rst) // R9
    anOn && !anComplete |=> !modeValid)
    else $error("mode valid before completion");
  chk_top_prio: assert property (@(posedge clk_sys) disable iff (rst) // R20
    anOn && anComplete && adv_r[ADV_T100F] && partnerAbility[ADV_T100F]
    |=> !speed10 && fullDuplex)
    else $error("priority resolution wrong");
  chk_bmc_hold: assert property (@(posedge clk_sys) disable iff (rst) // R8
    !(phase_r == ST_RUN && regWrite && regAddr == OFS_BMC)
    |=> bmc_r == $past(bmc_r))
    else $error("control word changed without a write");
  chk_strap_hold: assert property (@(posedge clk_sys) disable iff (rst) // R22
    phase_r == ST_RUN && !(regWrite && regAddr == OFS_ADV)
    |=> adv_r == $past(adv_r) && strapAn_r == $past(strapAn_r))
    else $error("strap result moved after capture");
  chk_restart_bit: assert property (@(posedge clk_sys) disable iff (rst) // R5
    phase_r == ST_RUN && regWrite && regAddr == OFS_BMC &&
    regWdata[BMC_RESTART] |=> anRestart && !bmc_r[BMC_RESTART])
    else $error("restart request not pulsed");
  chk_ctl_forced: assert property (@(posedge clk_sys) disable iff (rst) // R21
    swOwns_r && !bmc_r[BMC_ANEN] |=> modeValid &&
    speed10 == !$past(bmc_r[BMC_SPEED]) &&
    fullDuplex == $past(bmc_r[BMC_DUPLEX]))
    else $error("forced control bits not applied");
  chk_off_valid: assert property (@(posedge clk_sys) disable iff (rst) // R6 R9
    !anOn |=> modeValid && !flpEnable)
    else $error("forced mode not valid or bursts left on");

  // Forced strap rows: mode outputs settle two edges after the capture edge
  chk_force_10h: assert property (@(posedge clk_sys) disable iff (rst) // R11
    phase_r == ST_WAIT && lvlHigh == LVL_LOW && lvlLow == LVL_MID
    |=> ##1 modeValid && speed10 && !fullDuplex)
    else $error("strap forced 10 half not applied");
  chk_force_10f: assert property (@(posedge clk_sys) disable iff (rst) // R12
    phase_r == ST_WAIT && lvlHigh == LVL_HIGH && lvlLow == LVL_MID
    |=> ##1 modeValid && speed10 && fullDuplex)
    else $error("strap forced 10 full not applied");
  chk_force_100h: assert property (@(posedge clk_sys) disable iff (rst) // R13
    phase_r == ST_WAIT && lvlHigh == LVL_MID && lvlLow == LVL_LOW
    |=> ##1 modeValid && !speed10 && !fullDuplex)
    else $error("strap forced 100 half not applied");
  chk_force_100f: assert property (@(posedge clk_sys) disable iff (rst) // R14
    phase_r == ST_WAIT && lvlHigh == LVL_MID && lvlLow == LVL_HIGH
    |=> ##1 modeValid && !speed10 && fullDuplex)
    else $error("strap forced 100 full not applied");

  // Advertised strap rows: register value one edge after capture
  chk_adv_10only: assert property (@(posedge clk_sys) disable iff (rst) // R16
    phase_r == ST_WAIT && lvlHigh == LVL_LOW && lvlLow == LVL_LOW
    |=> adv_r == ADV_10ONLY && strapAn_r)
    else $error("low straps wrong advertisement");
  chk_adv_100only: assert property (@(posedge clk_sys) disable iff (rst) // R17
    phase_r == ST_WAIT && lvlHigh == LVL_LOW && lvlLow == LVL_HIGH
    |=> adv_r == ADV_100ONLY && strapAn_r)
    else $error("100 only straps wrong advertisement");
  chk_adv_half: assert property (@(posedge clk_sys) disable iff (rst) // R18
    phase_r == ST_WAIT && lvlHigh == LVL_HIGH && lvlLow == LVL_LOW
    |=> adv_r == ADV_HALF && strapAn_r)
    else $error("half duplex straps wrong advertisement");
  chk_adv_10half: assert property (@(posedge clk_sys) disable iff (rst) // R19
    phase_r == ST_WAIT && lvlHigh == LVL_HIGH && lvlLow == LVL_HIGH
    |=> adv_r == ADV_10HALF && strapAn_r)
    else $error("high straps wrong advertisement");
endmodule
`default_nettype wire

// ### dv/strap_partner.sv
// Board strap wiring and far-end ability model
`timescale 1ns/1ps
`default_nettype none
module strap_partner
  import autoneg_strap_pkg::*;
(
  // Requested pin levels and partner abilities
  input wire level_type hiLvl,
  input wire level_type loLvl,
  input wire logic [3:0] techSet,
  // Comparator pairs and partner word
  output logic strapLowA,
  output logic strapLowB,
  output logic strapHighA,
  output logic strapHighB,
  output logic [8:0] partnerAbility
);
  // Low gives LL, mid LH, high HH
  assign strapLowA = (loLvl == LVL_HIGH);
  assign strapLowB = (loLvl != LVL_LOW);
  assign strapHighA = (hiLvl == LVL_HIGH);
  assign strapHighB = (hiLvl != LVL_LOW);
  // Selector 00001 keeps the word a valid base page
  assign partnerAbility = {techSet, 5'h01};
endmodule
`default_nettype wire

// ### dv/test_autoneg_strap_config.sv
// Testbench for the strap loader and mode resolution
`timescale 1ns/1ps
`default_nettype none
module test_autoneg_strap_config;
  import autoneg_strap_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000, regRdata, rd;
  logic anComplete = 1'b0, linkUp = 1'b0;
  logic [3:0] techSet = 4'h0;
  level_type hiLvl = LVL_MID, loLvl = LVL_MID;
  logic sLA, sLB, sHA, sHB, flpEnable, anRestart, speed10, fullDuplex;
  logic modeValid;
  logic [8:0] partnerAbility, flpAbility;
  int nErrors = 0, cmpCount = 0, nRestart = 0;
  level_type hiT[9] = '{LVL_LOW, LVL_HIGH, LVL_MID, LVL_MID, LVL_MID,
    LVL_LOW, LVL_LOW, LVL_HIGH, LVL_HIGH};
  level_type loT[9] = '{LVL_MID, LVL_MID, LVL_LOW, LVL_HIGH, LVL_MID,
    LVL_LOW, LVL_HIGH, LVL_LOW, LVL_HIGH};
  logic [8:0] advT[9] = '{9'h021, 9'h041, 9'h081, 9'h101, 9'h1e1, 9'h061,
    9'h181, 9'h0a1, 9'h021};
  // Duplex and speed10 status bits; meaningful in forced rows only
  logic [1:0] stsT[9] = '{2'b01, 2'b11, 2'b00, 2'b10, 2'b00, 2'b00,
    2'b00, 2'b00, 2'b00};
  strap_partner farSide (.hiLvl(hiLvl), .loLvl(loLvl), .techSet(techSet),
    .strapLowA(sLA), .strapLowB(sLB), .strapHighA(sHA), .strapHighB(sHB),
    .partnerAbility(partnerAbility));
  autoneg_strap_config DUT (.clk_sys(clk_sys), .rst(rst), .strapLowA(sLA),
    .strapLowB(sLB), .strapHighA(sHA), .strapHighB(sHB),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata),
    .partnerAbility(partnerAbility), .anComplete(anComplete),
    .linkUp(linkUp), .flpAbility(flpAbility), .flpEnable(flpEnable),
    .anRestart(anRestart), .speed10(speed10), .fullDuplex(fullDuplex),
    .modeValid(modeValid));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // Restart is a one-cycle pulse, so count it rather than poll it
  always @(negedge clk_sys) begin
    if (anRestart === 1'b1) nRestart++;
  end
  task automatic test_done();
    $display("Compares %0d, mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic regRd(input logic [7:0] a);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 rd = regRdata;
  endtask
  task automatic regWr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // Mode outputs packed as {modeValid, speed10, fullDuplex}
  task automatic mode(input logic [2:0] exp);
    check("mode", {13'h0, modeValid, speed10, fullDuplex}, {13'h0, exp});
  endtask
  // Straps settle during reset; capture happens on the first edge after
  task automatic strapReset(input level_type h, l);
    @(posedge clk_sys);
    hiLvl <= h;
    loLvl <= l;
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    nErrors++;
    test_done();
  end
  initial begin
    for (int i = 0; i < 9; i++) begin
      strapReset(hiT[i], loT[i]);
      regRd(OFS_ADV);
      check("adv", rd, {7'h0, advT[i]});
      regRd(OFS_STS);
      check("strapAn", {15'h0, rd[9]}, {15'h0, i > 3});
      if (i < 4) check("forced", {14'h0, rd[2:1]}, {14'h0, stsT[i]});
      check("flpEn", {15'h0, flpEnable}, {15'h0, i > 3});
      regRd(OFS_BMC);
      check("ctl", rd, 16'h3100);
      $display("Strap row %0d done", i);
    end
    // Both mid captured; later strap moves must be ignored
    strapReset(LVL_MID, LVL_MID);
    hiLvl <= LVL_LOW;
    loLvl <= LVL_LOW;
    repeat (4) @(posedge clk_sys);
    regRd(OFS_ADV);
    check("advHeld", rd, 16'h01e1);
    regWr(OFS_BMC, 16'h1200);
    mode(3'b000);
    @(posedge clk_sys);
    techSet <= 4'b0110;
    anComplete <= 1'b1;
    linkUp <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 mode(3'b100);
    @(posedge clk_sys);
    techSet <= 4'b1110;
    repeat (3) @(posedge clk_sys);
    #1 mode(3'b101);
    regWr(OFS_ADV, 16'h0061);
    regRd(OFS_ADV);
    check("advWr", rd, 16'h0061);
    check("flpAbil", {7'h0, flpAbility}, 16'h0061);
    mode(3'b111);
    regWr(OFS_STS, 16'hffff);
    regRd(OFS_STS);
    check("sts", rd, 16'h0217);
    regRd(8'h20);
    check("unmapped", rd, 16'h0000);
    $display("Negotiation test done");
    regWr(OFS_BMC, 16'h2100);
    mode(3'b101);
    check("flpOff", {15'h0, flpEnable}, 16'h0000);
    regWr(OFS_BMC, 16'h0000);
    mode(3'b110);
    regRd(OFS_BMC);
    check("ctlWr", rd, 16'h0000);
    regWr(OFS_BMC, 16'h1000);
    mode(3'b111);
    check("flpOn", {15'h0, flpEnable}, 16'h0001);
    check("restarts", nRestart[15:0], 16'h0002);
    $display("Forced control test done");
    test_done();
  end
endmodule
`default_nettype wire
